// ---- dac_span_defines.svh ----
// constants for the span, step and serial control of the 12-bit dac
// assumes one 125 MHz clock; included by its bare name
`ifndef DAC_SPAN_DEFINES_SVH
`define DAC_SPAN_DEFINES_SVH

// memory addresses inside the 64-byte map
`define DAC_MSB_ADDR     6'h38
`define DAC_LSB_ADDR     6'h39
`define SPAN_CFG_ADDR    6'h3c
`define NV_SEL_ADDR      6'h3f

// span_and_step_config fields
`define CFG_RESET        8'h84
`define CFG_FULL_MSB     7
`define CFG_FULL_LSB     5
`define CFG_ZERO_MSB     4
`define CFG_ZERO_LSB     2
`define CFG_EIGHT_BIT    1
`define CFG_TEN_BIT      0
`define REF_EXTERNAL     3'h0
`define NV_SEL_BIT       7

// timing
`define CLK_MHZ          125
`define RDY_DELAY_US     100
`define STEP_MAX_KHZ     500

`endif

// ---- dac_span_types_pkg.sv ----
// types shared by the dac span and step control
// assumes dac_span_defines.svh carries the numbers
package dac_span_types_pkg;

    typedef enum logic [1:0] {
        step_full,
        step_ten,
        step_eight
    } step_mode_t;

    typedef logic [2:0]  ref_code_t;
    typedef logic [11:0] dac_word_t;

endpackage : dac_span_types_pkg

// ---- dac_span_step_control.sv ----
// span configuration, up/down stepping, clear and serial slave of a 12-bit dac
// assumes every pin input is asynchronous to clk; the analog core reads the registered outputs
// How it works
// - top three config bits at 3Ch pick full-scale reference, 000 external
// - next three config bits pick zero-scale reference, 000 external
// - reference code 000b releases that reference pin as an input
// - span fields live in non-volatile store and reload at every power-up
// - step select bits pick full word, 10 msbs or 8 msbs
// - 10-bit stepping starts at bit 2, 8-bit at bit 4
// - chip select high: step-up falling edge with step-down low adds one
// - chip select high: step-down falling edge with step-up low subtracts one
// - step pins only act with chip select high; low means serial control
// - steps up to 500 kHz are never lost
// - clear pin high asynchronously zeroes dac and serial input registers
// - undriven clear is inactive; clear ignored while ready is high
// - buffer enable low floats the buffered output, high drives it
// - ready released during power-up, driven low after delay, released on brownout
// - code fff gives full-scale reference, code 000 zero-scale
// - sample si on rising sck with cs and ready low; change so on falling sck
// - commands start at falling cs; end by raising cs after last bit
// - dac bytes 38h and 39h form one 12-bit code, upper byte first
`timescale 1ns/10ps
`include "dac_span_defines.svh"

module dac_span_step_control #(
    parameter int RDY_DELAY_CYCLES = `RDY_DELAY_US * `CLK_MHZ
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          cs_n,
    input  wire logic                          sck,
    input  wire logic                          si,
    output logic                               so,
    output logic                               so_oe,
    input  wire logic                          step_up,
    input  wire logic                          step_down,
    input  wire logic                          async_zero_pin,
    input  wire logic                          buffer_enable,
    input  wire logic                          supply_ok,
    input  wire logic                          factory_load,
    output logic                               rdy_n_out,
    output logic                               rdy_n_oe,
    output dac_span_types_pkg::dac_word_t      dac_code,
    output dac_span_types_pkg::ref_code_t      full_scale_ref_sel,
    output dac_span_types_pkg::ref_code_t      zero_scale_ref_sel,
    output logic                               full_scale_ref_drive,
    output logic                               zero_scale_ref_drive,
    output logic                               buffer_drive,
    output logic                               nv_readback_select
);
    import dac_span_types_pkg::*;

    localparam int NSYNC = 7;

    // synchronisers: cs_n, sck, si, step_up, step_down, buffer_enable, supply_ok
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic             cs_prev;
    logic             sck_prev;
    logic             up_prev;
    logic             down_prev;

    always_ff @(posedge clk) begin
        sync_a <= {cs_n, sck, si, step_up, step_down, buffer_enable, supply_ok};
        sync_b <= sync_a;
    end

    wire cs_s     = sync_b[6];
    wire sck_s    = sync_b[5];
    wire si_s     = sync_b[4];
    wire up_s     = sync_b[3];
    wire down_s   = sync_b[2];
    wire oe_s     = sync_b[1];
    wire supply_s = sync_b[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_prev   <= 1'b1;
            sck_prev  <= 1'b0;
            up_prev   <= 1'b0;
            down_prev <= 1'b0;
        end else begin
            cs_prev   <= cs_s;
            sck_prev  <= sck_s;
            up_prev   <= up_s;
            down_prev <= down_s;
        end
    end

    // power-ready sequencing
    logic [31:0] rdy_cnt;
    logic        rdy_low;

    always_ff @(posedge clk) begin
        if (rst || !supply_s) begin
            rdy_cnt <= 32'h0;
            rdy_low <= 1'b0;
        end else if (rdy_cnt >= 32'(RDY_DELAY_CYCLES - 1)) begin
            rdy_low <= 1'b1;
        end else begin
            rdy_cnt <= rdy_cnt + 32'h1;
        end
    end

    // serial framing state
    logic [2:0]  bit_cnt;
    logic [1:0]  byte_idx;
    logic        is_read;
    logic        aborted;
    logic [5:0]  ptr;
    logic [2:0]  tx_cnt;
    logic [7:0]  tx_shift;
    logic [7:0]  rx_shift;
    logic [7:0]  msb_hold;
    logic [7:0]  cfg;
    logic [7:0]  nv_cfg;
    logic        nv_sel;

    wire frame_on    = !cs_s && !cs_prev;
    wire sck_rise_ok = frame_on && rdy_low && sck_s && !sck_prev;
    wire sck_fall    = frame_on && !sck_s && sck_prev;
    wire byte_done   = sck_rise_ok && (bit_cnt == 3'h7);
    wire [7:0] rx_byte = {rx_shift[6:0], si_s};
    wire data_phase  = (byte_idx == 2'h2) && !aborted;
    wire wr_byte     = byte_done && data_phase && !is_read;
    wire read_active = data_phase && is_read;
    wire wr_msb      = wr_byte && (ptr == `DAC_MSB_ADDR);
    wire wr_lsb      = wr_byte && (ptr == `DAC_LSB_ADDR);
    wire wr_cfg      = wr_byte && (ptr == `SPAN_CFG_ADDR);
    wire wr_nvsel    = wr_byte && (ptr == `NV_SEL_ADDR);
    wire [5:0] ptr_page_next = {ptr[5:3], ptr[2:0] + 3'h1};

    // read data mux; dac bytes show the volatile code
    wire [7:0] rd_byte =
        (ptr == `DAC_MSB_ADDR)  ? dac_code[11:4] :
        (ptr == `DAC_LSB_ADDR)  ? {dac_code[3:0], 4'h0} :
        (ptr == `SPAN_CFG_ADDR) ? cfg :
        (ptr == `NV_SEL_ADDR)   ? {nv_sel, 7'h0} : 8'h00;

    // step decode
    wire       step_enable = cs_s;
    wire       up_event    = step_enable && up_prev && !up_s && !down_s;
    wire       down_event  = step_enable && down_prev && !down_s && !up_s;
    wire [1:0] step_bits   = {cfg[`CFG_EIGHT_BIT], cfg[`CFG_TEN_BIT]};
    step_mode_t step_mode;
    assign step_mode = (step_bits == 2'b01) ? step_ten :
                       (step_bits == 2'b10) ? step_eight : step_full;

    function automatic dac_word_t stepped(input dac_word_t c, input step_mode_t m,
                                          input logic up);
        dac_word_t r;
        r = c;
        unique case (m)
            step_ten: begin
                r = {(up ? c[11:2] + 10'h1 : c[11:2] - 10'h1), c[1:0]};
            end
            step_eight: begin
                r = {(up ? c[11:4] + 8'h1 : c[11:4] - 8'h1), c[3:0]};
            end
            step_full: begin
                r = up ? c + 12'h1 : c - 12'h1;
            end
        endcase
        return r;
    endfunction : stepped

    dac_word_t next_code;
    assign next_code = wr_lsb     ? {msb_hold, rx_byte[7:4]} :
                       up_event   ? stepped(dac_code, step_mode, 1'b1) :
                       down_event ? stepped(dac_code, step_mode, 1'b0) :
                       dac_code;

    wire [7:0] next_msb = wr_msb ? rx_byte : msb_hold;
    wire [7:0] next_rx  = sck_rise_ok ? rx_byte : rx_shift;

    // clear acts without the clock; the on-chip pulldown makes an open pin low
    wire clear_now = async_zero_pin && rdy_low;

    always_ff @(posedge clk or posedge clear_now) begin
        if (clear_now) begin
            dac_code <= 12'h000;
            msb_hold <= 8'h00;
            rx_shift <= 8'h00;
        end else if (rst) begin
            dac_code <= 12'h000;
            msb_hold <= 8'h00;
            rx_shift <= 8'h00;
        end else begin
            dac_code <= next_code;
            msb_hold <= next_msb;
            rx_shift <= next_rx;
        end
    end

    // non-volatile span store: survives rst, which stands for power cycling
    always_ff @(posedge clk) begin
        if (factory_load) begin
            nv_cfg <= `CFG_RESET;
        end else if (wr_cfg) begin
            nv_cfg <= rx_byte;
        end
    end

    // working configuration reloads from the store at power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= nv_cfg;
        end else if (factory_load) begin
            cfg <= `CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= rx_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nv_sel <= 1'b0;
        end else if (wr_nvsel) begin
            nv_sel <= rx_byte[`NV_SEL_BIT];
        end
    end

    // receive framing: a frame starts at falling cs and dies at rising cs
    always_ff @(posedge clk) begin
        if (rst || cs_s) begin
            bit_cnt  <= 3'h0;
            byte_idx <= 2'h0;
            is_read  <= 1'b0;
            aborted  <= 1'b0;
        end else if (sck_rise_ok) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done && byte_idx != 2'h2) begin
                byte_idx <= byte_idx + 2'h1;
            end
            if (byte_done && byte_idx == 2'h0) begin
                is_read <= rx_byte[0];
            end
            if (byte_done && byte_idx == 2'h1 && rx_byte[7:6] != 2'h0) begin
                aborted <= 1'b1;
            end
        end
    end

    // address pointer: writes wrap in the page, reads over the whole map
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= 6'h00;
        end else if (byte_done && byte_idx == 2'h1) begin
            ptr <= rx_byte[5:0];
        end else if (wr_byte) begin
            ptr <= ptr_page_next;
        end else if (sck_fall && read_active && tx_cnt == 3'h0) begin
            ptr <= ptr + 6'h1;
        end
    end

    // transmit on falling sck, first bit after the address byte
    always_ff @(posedge clk) begin
        if (rst || cs_s) begin
            tx_cnt   <= 3'h0;
            tx_shift <= 8'h00;
            so       <= 1'b0;
            so_oe    <= 1'b0;
        end else begin
            so_oe <= read_active;
            if (sck_fall && read_active) begin
                tx_cnt <= tx_cnt + 3'h1;
                if (tx_cnt == 3'h0) begin
                    so       <= rd_byte[7];
                    tx_shift <= {rd_byte[6:0], 1'b0};
                end else begin
                    so       <= tx_shift[7];
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end
            end
        end
    end

    // registered pins toward the analog core
    always_ff @(posedge clk) begin
        if (rst) begin
            full_scale_ref_sel   <= `REF_EXTERNAL;
            zero_scale_ref_sel   <= `REF_EXTERNAL;
            full_scale_ref_drive <= 1'b0;
            zero_scale_ref_drive <= 1'b0;
            buffer_drive         <= 1'b0;
            nv_readback_select   <= 1'b0;
            rdy_n_out            <= 1'b0;
            rdy_n_oe             <= 1'b0;
        end else begin
            full_scale_ref_sel   <= cfg[`CFG_FULL_MSB:`CFG_FULL_LSB];
            zero_scale_ref_sel   <= cfg[`CFG_ZERO_MSB:`CFG_ZERO_LSB];
            full_scale_ref_drive <= cfg[`CFG_FULL_MSB:`CFG_FULL_LSB] != `REF_EXTERNAL;
            zero_scale_ref_drive <= cfg[`CFG_ZERO_MSB:`CFG_ZERO_LSB] != `REF_EXTERNAL;
            buffer_drive         <= oe_s;
            nv_readback_select   <= nv_sel;
            rdy_n_out            <= 1'b0;
            rdy_n_oe             <= rdy_low;
        end
    end

endmodule : dac_span_step_control

// ---- dac_span_master.sv ----
// spi master and step-pin driver facing the dac control block
// assumes the bench clk; every pin changes just after a clk edge
`timescale 1ns/10ps

module dac_span_master (
    input  wire logic clk,
    input  wire logic so,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      step_up,
    output logic      step_down
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        step_up = 1'b0;
        step_down = 1'b0;
    end

    // one byte msb first at 64 ns a bit; so is taken at rising sck
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si <= b[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            r[i] = so;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
    endtask : xfer

    // id byte, address byte, then n data bytes
    task automatic frame(input logic [7:0] id, a, d0, d1, input int n,
                         output logic [7:0] r);
        logic [7:0] t;
        cs_n <= 1'b0;
        repeat (13) @(posedge clk);
        xfer(id, t);
        xfer(a, t);
        xfer(d0, r);
        if (n > 1) xfer(d1, t);
        repeat (13) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (13) @(posedge clk);
    endtask : frame

    task automatic sel(input logic v);
        cs_n <= v;
        repeat (13) @(posedge clk);
    endtask : sel

    // 1 us high then 1 us low on one pin, the other held low
    task automatic step(input logic up);
        if (up) step_up <= 1'b1;
        else step_down <= 1'b1;
        repeat (125) @(posedge clk);
        step_up <= 1'b0;
        step_down <= 1'b0;
        repeat (125) @(posedge clk);
    endtask : step
endmodule : dac_span_master

// ---- dac_span_step_control_assertions.sv ----
// port-level checks of the dac span and step control
// assumes one clk domain with synchronous active-high rst
`timescale 1ns/10ps

module dac_span_step_control_assertions
    import dac_span_types_pkg::*;
#(
    parameter int RDY_DELAY_CYCLES = 12500
) (
    input wire logic      clk,
    input wire logic      rst,
    input wire logic      cs_n,
    input wire logic      supply_ok,
    input wire logic      async_zero_pin,
    input wire logic      buffer_enable,
    input wire logic      so_oe,
    input wire logic      rdy_n_out,
    input wire logic      rdy_n_oe,
    input wire dac_word_t dac_code,
    input wire ref_code_t full_scale_ref_sel,
    input wire ref_code_t zero_scale_ref_sel,
    input wire logic      full_scale_ref_drive,
    input wire logic      zero_scale_ref_drive,
    input wire logic      buffer_drive
);
    int sup_cnt;

    // cycles of good supply since reset or the last supply loss, saturating
    always_ff @(posedge clk) begin
        if (rst || !supply_ok) begin
            sup_cnt <= 0;
        end else if (sup_cnt < RDY_DELAY_CYCLES) begin
            sup_cnt <= sup_cnt + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reset_state_a: assert property (
        $fell(rst) |-> dac_code == 12'h000 && !so_oe && !rdy_n_oe) else $error("reset state");
    ready_delay_a: assert property (
        $rose(rdy_n_oe) |-> sup_cnt == RDY_DELAY_CYCLES) else $error("ready early");
    ready_drop_a: assert property (
        $fell(supply_ok) |-> ##[1:5] !rdy_n_oe) else $error("ready kept");
    ready_level_a: assert property (
        rdy_n_oe |-> !rdy_n_out) else $error("ready level");
    clear_zero_a: assert property (
        async_zero_pin && rdy_n_oe |-> dac_code == 12'h000) else $error("clear missed");
    so_release_a: assert property (
        cs_n [*8] |-> !so_oe) else $error("so driven");
    full_drive_a: assert property (
        1'b1 |-> ##[0:1] full_scale_ref_drive == (full_scale_ref_sel != 3'h0))
        else $error("full drive");
    zero_drive_a: assert property (
        1'b1 |-> ##[0:1] zero_scale_ref_drive == (zero_scale_ref_sel != 3'h0))
        else $error("zero drive");
    buf_on_a: assert property (
        $rose(buffer_enable) |-> ##[1:4] buffer_drive) else $error("buffer on");
    buf_off_a: assert property (
        $fell(buffer_enable) |-> ##[1:4] !buffer_drive) else $error("buffer off");

    cover property ($rose(rdy_n_oe));
    cover property ($rose(so_oe));
    cover property (!$stable(dac_code) && cs_n);
endmodule : dac_span_step_control_assertions

bind dac_span_step_control dac_span_step_control_assertions #(
    .RDY_DELAY_CYCLES(RDY_DELAY_CYCLES)
) i_chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .supply_ok(supply_ok),
    .async_zero_pin(async_zero_pin), .buffer_enable(buffer_enable), .so_oe(so_oe),
    .rdy_n_out(rdy_n_out), .rdy_n_oe(rdy_n_oe), .dac_code(dac_code),
    .full_scale_ref_sel(full_scale_ref_sel), .zero_scale_ref_sel(zero_scale_ref_sel),
    .full_scale_ref_drive(full_scale_ref_drive),
    .zero_scale_ref_drive(zero_scale_ref_drive), .buffer_drive(buffer_drive)
);

// ---- tb_top.sv ----
// self-checking bench for the dac span and step control
// assumes the master model of dac_span_master.sv
`timescale 1ns/10ps

module tb_top;
    import dac_span_types_pkg::*;
    localparam int RDY = 20;
    logic       clk, rst, cs_n, sck, si, so, so_oe, step_up, step_down, fdrv, zdrv;
    logic       async_zero_pin, buffer_enable, supply_ok, factory_load;
    logic       rdy_n_out, rdy_n_oe, buffer_drive, nvsel;
    dac_word_t  dac_code;
    ref_code_t  fsel, zsel;
    logic [7:0] r;
    int         error_cnt, check_count, cyc, sh;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    dac_span_master i_master (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si),
        .step_up(step_up), .step_down(step_down));

    dac_span_step_control #(.RDY_DELAY_CYCLES(RDY)) i_dut (
        .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
        .step_up(step_up), .step_down(step_down), .async_zero_pin(async_zero_pin),
        .buffer_enable(buffer_enable), .supply_ok(supply_ok), .factory_load(factory_load),
        .rdy_n_out(rdy_n_out), .rdy_n_oe(rdy_n_oe), .dac_code(dac_code),
        .full_scale_ref_sel(fsel), .zero_scale_ref_sel(zsel), .full_scale_ref_drive(fdrv),
        .zero_scale_ref_drive(zdrv), .buffer_drive(buffer_drive), .nv_readback_select(nvsel));

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic wait_rdy;
        for (int i = 0; i < 200 && rdy_n_oe !== 1'b1; i++) @(posedge clk);
        chk("ready", 12'h1, 12'(rdy_n_oe));
    endtask : wait_rdy

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test;
        end
    end

    initial begin
        rst = 1'b1;
        factory_load = 1'b1;
        async_zero_pin = 1'b0;
        buffer_enable = 1'b0;
        supply_ok = 1'b1;
        @(posedge clk);
        factory_load <= 1'b0;
        @(posedge clk);
        rst <= 1'b0;
        wait_rdy;
        chk("full sel", 12'h4, 12'(fsel));
        chk("zero sel", 12'h1, 12'(zsel));
        for (int f = 0; f < 6; f++) begin
            i_master.frame(8'h00, 8'h3c, {f[2:0], f[2:0], 2'b00}, 8'h00, 1, r);
            chk("full sel", 12'(f), 12'(fsel));
            chk("zero sel", 12'(f), 12'(zsel));
            chk("full drive", 12'(f != 0), 12'(fdrv));
            chk("zero drive", 12'(f != 0), 12'(zdrv));
        end
        $display("test span done");
        for (int md = 0; md < 4; md++) begin
            sh = (md == 1) ? 2 : (md == 2) ? 4 : 0;
            i_master.frame(8'h00, 8'h3c, {6'b101001, md[1:0]}, 8'h00, 1, r);
            i_master.frame(8'h00, 8'h38, 8'hff, 8'hf0, 2, r);
            i_master.step(1'b1);
            chk("step up", 12'hfff + (12'h1 << sh), dac_code);
            i_master.step(1'b0);
            chk("step down", 12'hfff, dac_code);
        end
        i_master.frame(8'h00, 8'h38, 8'ha5, 8'h3c, 2, r);
        chk("dac pair", 12'ha53, dac_code);
        i_master.frame(8'h01, 8'h38, 8'h00, 8'h00, 1, r);
        chk("read back", 12'h0a5, {4'h0, r});
        i_master.sel(1'b0);
        i_master.step(1'b1);
        i_master.sel(1'b1);
        chk("step with cs low", 12'ha53, dac_code);
        $display("test serial and steps done");
        async_zero_pin <= 1'b1;
        repeat (2) @(posedge clk);
        chk("clear", 12'h000, dac_code);
        async_zero_pin <= 1'b0;
        i_master.step(1'b1);
        supply_ok <= 1'b0;
        repeat (8) @(posedge clk);
        chk("ready off", 12'h0, 12'(rdy_n_oe));
        async_zero_pin <= 1'b1;
        repeat (4) @(posedge clk);
        chk("clear ignored", 12'h001, dac_code);
        async_zero_pin <= 1'b0;
        supply_ok <= 1'b1;
        wait_rdy;
        for (int v = 1; v >= 0; v--) begin
            buffer_enable <= v[0];
            repeat (6) @(posedge clk);
            chk("buffer drive", 12'(v), 12'(buffer_drive));
        end
        $display("test clear, ready and buffer done");
        i_master.frame(8'h00, 8'h3f, 8'h80, 8'h00, 1, r);
        chk("readback select", 12'h1, 12'(nvsel));
        i_master.frame(8'h00, 8'h3c, 8'h68, 8'h00, 1, r);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("readback select", 12'h0, 12'(nvsel));
        wait_rdy;
        chk("full sel", 12'h3, 12'(fsel));
        chk("zero sel", 12'h2, 12'(zsel));
        factory_load <= 1'b1;
        @(posedge clk);
        factory_load <= 1'b0;
        repeat (2) @(posedge clk);
        chk("full sel", 12'h4, 12'(fsel));
        chk("zero sel", 12'h1, 12'(zsel));
        i_master.frame(8'h00, 8'h7c, 8'h00, 8'h00, 1, r);
        chk("bad address", 12'h4, 12'(fsel));
        $display("test reload done");
        stop_test;
    end
endmodule : tb_top
